// *** adcc_conv_timer.sv ***
// Counts modulator ticks over one conversion and flags its end.
`default_nettype none
module adcc_conv_timer (
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    input wire logic i_start,
    input wire logic i_enable,
    input wire logic i_tick,
    input wire logic [11:0] i_length,
    output logic o_done
);
    logic [11:0] cnt_r;
    logic run_r;

    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            cnt_r <= 12'h000;
            run_r <= 1'b0;
            o_done <= 1'b0;
        end else begin
            o_done <= 1'b0;
            if (i_start) begin
                run_r <= 1'b1;
                cnt_r <= i_length;
            end else if (!i_enable) begin
                run_r <= 1'b0;
            end else if (run_r && i_tick) begin
                cnt_r <= cnt_r - 12'h001;
                if (cnt_r == 12'h001) begin
                    run_r <= 1'b0;
                    o_done <= 1'b1;
                end
            end
        end
    end
endmodule
`default_nettype wire

// *** adcc_ctrl.sv ***
// Register file, mode sequencing and calibration control of the converter.
`default_nettype none
// ****************************************
// Operation
// - Selector codes 0,2,3,4,6 route the documented node pairs; codes 1, 5 and 7 fall back to ground on both sides.
// - Mode 0 waits idle and converts nothing.
// - Mode 2 converts once with offset applied, then returns to idle.
// - Mode 3 converts repeatedly with offset until idle is written.
// - Mode 4 is single with polarity swap, half rate, no offset.
// - Mode 5 is continuous with polarity swap, third rate, no offset.
// - Mode 8 shorts inputs to ground, amp one off, measures offset.
// - Mode 9 applies reference, amp one off, stores gain coefficient.
// - Mode A shorts inputs together with set gains, stores offset.
// - Mode C measures system offset on selected pair.
// - Mode D measures system gain on selected pair.
// - Mode reads F after reset until boot ends, then idle.
// - Result is signed 16-bit, saturating at 0x8000 and 0x7fff.
// - Second amp gain code 0,1,2 gives one, two, four.
// - Gain register bit 3 switches the first amplifier.
// - First amp gain is two to the power of code.
// - Modulator clock is oscillator divided by 2,4,8,16.
// - Decimation ratio sets conversion length and data rate.
// - Power-on and serial reset command restore all defaults.
// ****************************************
module adcc_ctrl #(
    parameter logic [79:0] DEC_RATIO_TABLE = {10'd512, 10'd512, 10'd512, 10'd512,
                                               10'd512, 10'd256, 10'd128, 10'd64}
) (
    input wire logic i_sys_clk,
    input wire logic i_resetn,
    input wire logic i_soft_reset,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    input wire logic [3:0] i_reg_addr,
    input wire logic [7:0] i_reg_wdata,
    input wire logic [15:0] i_filter_data,
    output logic [7:0] o_reg_rdata,
    output logic o_data_ready_n,
    output logic [1:0] o_pos_node,
    output logic [1:0] o_neg_node,
    output logic o_first_amp_enable,
    output logic [2:0] o_first_amp_gain,
    output logic [1:0] o_second_amp_gain,
    output logic o_polarity_swap,
    output logic o_modulator_clock,
    output logic o_converting,
    output logic [23:0] o_offset_coef,
    output logic [23:0] o_gain_coef
);
    adcc_pkg::adcc_state_type state_r;
    logic rst;
    logic rst_n;
    logic [3:0] mode_r;
    logic [2:0] sel_r;
    logic [5:0] amp_cfg_r;
    logic [5:0] clk_cfg_r;
    logic [11:0] boot_cnt_r;
    logic [15:0] result_r;
    logic [7:0] shadow_r;
    logic start_r;
    logic first_r;
    logic ctrl_wr;
    logic host_cmd;
    logic is_cont;
    logic fin;
    logic mod_tick;
    logic conv_done;
    logic [9:0] ratio;
    logic [2:0] mult;
    logic [12:0] prod;
    logic [11:0] conv_len;
    logic [23:0] raw_ext;
    logic [24:0] ofs_term;
    logic signed [24:0] diff;
    logic [15:0] sat;
    logic [1:0] pos_nxt;
    logic [1:0] neg_nxt;
    logic a1en_nxt;
    logic [1:0] a2g_nxt;

    function automatic logic cmd_ok(input logic [3:0] m);
        case (m)
            adcc_pkg::MODE_IDLE, adcc_pkg::MODE_SINGLE, adcc_pkg::MODE_CONT,
            adcc_pkg::MODE_SINGLE_SWAP, adcc_pkg::MODE_CONT_SWAP,
            adcc_pkg::MODE_CAL_ADC_OFS, adcc_pkg::MODE_CAL_ADC_GAIN,
            adcc_pkg::MODE_CAL_AMP_OFS, adcc_pkg::MODE_CAL_SYS_OFS,
            adcc_pkg::MODE_CAL_SYS_GAIN: cmd_ok = 1'b1;
            default: cmd_ok = 1'b0;
        endcase
    endfunction

    // ****************************************
    // Reset, commands and timing helpers
    // ****************************************
    // The serial reset command acts exactly like power-on.
    assign rst = !i_resetn || i_soft_reset;
    assign rst_n = !rst;
    assign ctrl_wr = i_reg_wr && (i_reg_addr == adcc_pkg::ADDR_CTRL);
    // Reserved and boot codes are dropped from the mode, but the selector bits of such a write still update sel_r.
    assign host_cmd = ctrl_wr && (state_r != adcc_pkg::ST_BOOT)
                      && cmd_ok(i_reg_wdata[3:0]);
    assign is_cont = (mode_r == adcc_pkg::MODE_CONT) || (mode_r == adcc_pkg::MODE_CONT_SWAP);
    assign fin = conv_done && (state_r == adcc_pkg::ST_CONV) && !host_cmd;
    assign o_converting = state_r[2];

    adcc_modulator_clock_divider u_modulator_clock_divider (
        .i_sys_clk(i_sys_clk),
        .i_rst_n(rst_n),
        .i_div_code(clk_cfg_r[adcc_pkg::DIV_LSB+1:adcc_pkg::DIV_LSB]),
        .o_tick(mod_tick),
        .o_mod_clk(o_modulator_clock)
    );

    adcc_conv_timer u_timer (
        .i_sys_clk(i_sys_clk),
        .i_rst_n(rst_n),
        .i_start(start_r),
        .i_enable(o_converting),
        .i_tick(mod_tick),
        .i_length(conv_len),
        .o_done(conv_done)
    );

    // Mode 3 continuous conversions after the first need no filter settling; mode 5 settles every time.
    always_comb begin
        ratio = DEC_RATIO_TABLE[10*int'(clk_cfg_r[2:0]) +: 10];
        case (mode_r)
            adcc_pkg::MODE_SINGLE_SWAP: mult = adcc_pkg::MULT_SWAP_SINGLE;
            adcc_pkg::MODE_CONT: mult = first_r ? adcc_pkg::MULT_SETTLE : adcc_pkg::MULT_CONT;
            default: mult = adcc_pkg::MULT_SETTLE;
        endcase
        prod = 13'(ratio * mult);
        conv_len = prod[11:0];
    end

    // ****************************************
    // Boot and mode sequencing
    // ****************************************
    always_ff @(posedge i_sys_clk) begin
        if (rst) begin
            boot_cnt_r <= 12'h000;
        end else if (state_r == adcc_pkg::ST_BOOT) begin
            boot_cnt_r <= boot_cnt_r + 12'h001;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (rst) begin
            state_r <= adcc_pkg::ST_BOOT;
            mode_r <= adcc_pkg::MODE_BOOT;
            start_r <= 1'b0;
            first_r <= 1'b0;
        end else begin
            start_r <= 1'b0;
            case (state_r)
                adcc_pkg::ST_BOOT: begin
                    if (boot_cnt_r == adcc_pkg::BOOT_CYCLES - 12'h001) begin
                        state_r <= adcc_pkg::ST_IDLE;
                        mode_r <= adcc_pkg::MODE_IDLE;
                    end
                end
                adcc_pkg::ST_IDLE: begin
                    if (host_cmd) begin
                        mode_r <= i_reg_wdata[3:0];
                    end else if (mode_r != adcc_pkg::MODE_IDLE) begin
                        state_r <= adcc_pkg::ST_CONV;
                        start_r <= 1'b1;
                        first_r <= 1'b1;
                    end
                end
                adcc_pkg::ST_CONV: begin
                    // A new command aborts the running conversion.
                    if (host_cmd) begin
                        mode_r <= i_reg_wdata[3:0];
                        state_r <= adcc_pkg::ST_IDLE;
                    end else if (conv_done) begin
                        first_r <= 1'b0;
                        if (is_cont) begin
                            start_r <= 1'b1;
                        end else begin
                            mode_r <= adcc_pkg::MODE_IDLE;
                            state_r <= adcc_pkg::ST_IDLE;
                        end
                    end
                end
                default: begin
                    state_r <= adcc_pkg::ST_BOOT;
                end
            endcase
        end
    end

    // ****************************************
    // Configuration registers
    // ****************************************
    always_ff @(posedge i_sys_clk) begin
        if (rst) begin
            sel_r <= adcc_pkg::SEL_RST;
        end else if (ctrl_wr && state_r != adcc_pkg::ST_BOOT) begin
            sel_r <= i_reg_wdata[adcc_pkg::SEL_LSB+2:adcc_pkg::SEL_LSB];
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (rst) begin
            amp_cfg_r <= adcc_pkg::AMP_CFG_RST;
            clk_cfg_r <= adcc_pkg::CLK_CFG_RST;
        end else if (i_reg_wr && i_reg_addr == adcc_pkg::ADDR_AMP_CFG) begin
            amp_cfg_r <= i_reg_wdata[5:0];
        end else if (i_reg_wr && i_reg_addr == adcc_pkg::ADDR_CLK_CFG) begin
            clk_cfg_r <= {i_reg_wdata[5:4], 1'b0, i_reg_wdata[2:0]};
        end
    end

    // ****************************************
    // Input routing and amplifier control
    // ****************************************
    always_comb begin
        pos_nxt = adcc_pkg::NODE_GND;
        neg_nxt = adcc_pkg::NODE_GND;
        a1en_nxt = amp_cfg_r[adcc_pkg::AMP1_EN_BIT];
        a2g_nxt = amp_cfg_r[adcc_pkg::AMP2_LSB+1:adcc_pkg::AMP2_LSB];
        case (mode_r)
            adcc_pkg::MODE_CAL_ADC_OFS: begin
                a1en_nxt = 1'b0;
                a2g_nxt = 2'h0;
            end
            adcc_pkg::MODE_CAL_ADC_GAIN: begin
                a1en_nxt = 1'b0;
                a2g_nxt = 2'h0;
                pos_nxt = adcc_pkg::NODE_REF;
            end
            adcc_pkg::MODE_CAL_AMP_OFS: begin
                // Gains stay as the host programmed them beforehand.
                pos_nxt = adcc_pkg::NODE_NEG;
                neg_nxt = adcc_pkg::NODE_NEG;
            end
            default: begin
                // Reserved selector codes fall back to ground on both sides.
                case (sel_r)
                    3'h0: begin
                        pos_nxt = adcc_pkg::NODE_POS;
                        neg_nxt = adcc_pkg::NODE_NEG;
                    end
                    3'h2: pos_nxt = adcc_pkg::NODE_POS;
                    3'h3: pos_nxt = adcc_pkg::NODE_NEG;
                    3'h4: pos_nxt = adcc_pkg::NODE_REF;
                    3'h6: begin
                        pos_nxt = adcc_pkg::NODE_NEG;
                        neg_nxt = adcc_pkg::NODE_NEG;
                    end
                    default: pos_nxt = adcc_pkg::NODE_GND;
                endcase
            end
        endcase
    end

    always_ff @(posedge i_sys_clk) begin
        if (rst) begin
            o_pos_node <= adcc_pkg::NODE_GND;
            o_neg_node <= adcc_pkg::NODE_GND;
            o_first_amp_enable <= 1'b0;
            o_first_amp_gain <= 3'h0;
            o_second_amp_gain <= 2'h0;
            o_polarity_swap <= 1'b0;
        end else begin
            o_pos_node <= pos_nxt;
            o_neg_node <= neg_nxt;
            o_first_amp_enable <= a1en_nxt;
            o_first_amp_gain <= amp_cfg_r[2:0];
            o_second_amp_gain <= a2g_nxt;
            o_polarity_swap <= (mode_r == adcc_pkg::MODE_SINGLE_SWAP)
                               || (mode_r == adcc_pkg::MODE_CONT_SWAP);
        end
    end

    // ****************************************
    // Result and coefficients
    // ****************************************
    always_comb begin
        raw_ext = {{8{i_filter_data[15]}}, i_filter_data};
        if ((mode_r == adcc_pkg::MODE_SINGLE) || (mode_r == adcc_pkg::MODE_CONT)) begin
            ofs_term = {o_offset_coef[23], o_offset_coef};
        end else begin
            ofs_term = 25'h0000000;
        end
        diff = $signed({raw_ext[23], raw_ext}) - $signed(ofs_term);
        if (diff > 25'sh0007fff) begin
            sat = 16'h7fff;
        end else if (diff < 25'sh1ff8000) begin
            sat = 16'h8000;
        end else begin
            sat = diff[15:0];
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (rst) begin
            result_r <= 16'h0000;
        end else if (fin && mode_r <= adcc_pkg::MODE_CONT_SWAP) begin
            result_r <= sat;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (rst) begin
            o_offset_coef <= adcc_pkg::OFS_COEF_RST;
            o_gain_coef <= adcc_pkg::GAIN_COEF_RST;
        end else if (fin) begin
            case (mode_r)
                adcc_pkg::MODE_CAL_ADC_OFS, adcc_pkg::MODE_CAL_AMP_OFS,
                adcc_pkg::MODE_CAL_SYS_OFS: o_offset_coef <= raw_ext;
                adcc_pkg::MODE_CAL_ADC_GAIN,
                adcc_pkg::MODE_CAL_SYS_GAIN: o_gain_coef <= {8'h00, i_filter_data};
                default: o_gain_coef <= o_gain_coef;
            endcase
        end
    end

    // ****************************************
    // Read port and ready flag
    // ****************************************
    // A fresh result wins over the clear caused by reading the low byte.
    always_ff @(posedge i_sys_clk) begin
        if (rst) begin
            o_data_ready_n <= 1'b1;
        end else if (fin && mode_r <= adcc_pkg::MODE_CONT_SWAP) begin
            o_data_ready_n <= 1'b0;
        end else if (i_reg_rd && i_reg_addr == adcc_pkg::ADDR_RES_LO) begin
            o_data_ready_n <= 1'b1;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (rst) begin
            shadow_r <= 8'h00;
            o_reg_rdata <= 8'h00;
        end else if (i_reg_rd) begin
            case (i_reg_addr)
                adcc_pkg::ADDR_CTRL: o_reg_rdata <= {o_data_ready_n, sel_r, mode_r};
                adcc_pkg::ADDR_RES_HI: begin
                    // Freezing the low half keeps the pair from one conversion.
                    o_reg_rdata <= result_r[15:8];
                    shadow_r <= result_r[7:0];
                end
                adcc_pkg::ADDR_RES_LO: o_reg_rdata <= shadow_r;
                adcc_pkg::ADDR_AMP_CFG: o_reg_rdata <= {2'b00, amp_cfg_r};
                adcc_pkg::ADDR_CLK_CFG: o_reg_rdata <= {2'b00, clk_cfg_r};
                default: o_reg_rdata <= 8'h00;
            endcase
        end
    end

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (rst);

    property p_boot_end;
        state_r == adcc_pkg::ST_BOOT && boot_cnt_r == adcc_pkg::BOOT_CYCLES - 12'h001
        |=> mode_r == adcc_pkg::MODE_IDLE && state_r == adcc_pkg::ST_IDLE;
    endproperty
    a_boot_end: assert property (p_boot_end)
        else $error("boot did not end in idle");

    property p_boot_ro;
        state_r == adcc_pkg::ST_BOOT && boot_cnt_r < 12'h0fe |=> mode_r == adcc_pkg::MODE_BOOT;
    endproperty
    a_boot_ro: assert property (p_boot_ro)
        else $error("mode left boot early");

    property p_idle;
        state_r == adcc_pkg::ST_IDLE && mode_r == adcc_pkg::MODE_IDLE && !ctrl_wr
        |=> !o_converting [*2];
    endproperty
    a_idle: assert property (p_idle)
        else $error("conversion without command");

    property p_single_end;
        fin && mode_r == adcc_pkg::MODE_SINGLE
        |=> mode_r == adcc_pkg::MODE_IDLE && result_r == $past(sat) && !o_data_ready_n;
    endproperty
    a_single_end: assert property (p_single_end)
        else $error("single conversion did not finish");

    property p_cont_go;
        fin && mode_r == adcc_pkg::MODE_CONT |=> start_r && o_converting;
    endproperty
    a_cont_go: assert property (p_cont_go)
        else $error("continuous conversion stopped");

    property p_swap_raw;
        fin && (mode_r == adcc_pkg::MODE_SINGLE_SWAP || mode_r == adcc_pkg::MODE_CONT_SWAP)
        && i_filter_data[15:14] == 2'b00 |=> result_r == $past(i_filter_data);
    endproperty
    a_swap_raw: assert property (p_swap_raw)
        else $error("offset applied in swap mode");

    property p_cal_adc;
        mode_r == adcc_pkg::MODE_CAL_ADC_OFS |=> !o_first_amp_enable
        && o_second_amp_gain == 2'h0 && o_pos_node == adcc_pkg::NODE_GND
        && o_neg_node == adcc_pkg::NODE_GND;
    endproperty
    a_cal_adc: assert property (p_cal_adc)
        else $error("offset calibration routing wrong");

    property p_cal_store;
        fin && (mode_r == adcc_pkg::MODE_CAL_ADC_GAIN || mode_r == adcc_pkg::MODE_CAL_SYS_GAIN)
        |=> o_gain_coef == {8'h00, $past(i_filter_data)} && mode_r == adcc_pkg::MODE_IDLE;
    endproperty
    a_cal_store: assert property (p_cal_store)
        else $error("gain coefficient not stored");

    property p_route;
        (mode_r == adcc_pkg::MODE_SINGLE || mode_r == adcc_pkg::MODE_CONT) && sel_r == 3'h3
        |=> o_pos_node == adcc_pkg::NODE_NEG && o_neg_node == adcc_pkg::NODE_GND;
    endproperty
    a_route: assert property (p_route)
        else $error("input pair routing wrong");

    property p_amp;
        mode_r == adcc_pkg::MODE_CONT |=> o_first_amp_gain == $past(amp_cfg_r[2:0])
        && o_first_amp_enable == $past(amp_cfg_r[3]) && o_second_amp_gain == $past(amp_cfg_r[5:4]);
    endproperty
    a_amp: assert property (p_amp)
        else $error("amplifier settings not passed");

    c_single: cover property (fin && mode_r == adcc_pkg::MODE_SINGLE);
    c_cont_twice: cover property (fin && is_cont ##[1:1000] fin && is_cont);
    c_cal: cover property (fin && mode_r == adcc_pkg::MODE_CAL_ADC_OFS);
endmodule
`default_nettype wire

// *** adcc_filter_model.sv ***
// Behavioural filter output that feeds the converter control block.
`default_nettype none
module adcc_filter_model #(
    parameter logic [15:0] VALUE = 16'h1234
) (
    input wire logic i_sys_clk,
    output var logic [15:0] o_data
);
    timeunit 1ns;
    timeprecision 1ps;
    // A fixed sample keeps every expected result easy to derive.
    always_ff @(posedge i_sys_clk) begin
        o_data <= VALUE;
    end
endmodule
`default_nettype wire

// *** adcc_modulator_clock_divider.sv ***
// Modulator clock divider from the oscillator clock.
`default_nettype none
module adcc_modulator_clock_divider (
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    input wire logic [1:0] i_div_code,
    output logic o_tick,
    output logic o_mod_clk
);
    logic [3:0] cnt_r;
    logic [3:0] last;

    // Divide by two to the power of code plus one.
    assign last = 4'((5'h02 << i_div_code) - 5'h01);

    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            cnt_r <= 4'h0;
            o_tick <= 1'b0;
            o_mod_clk <= 1'b0;
        end else begin
            o_tick <= (cnt_r == last);
            cnt_r <= (cnt_r >= last) ? 4'h0 : cnt_r + 4'h1;
            o_mod_clk <= (cnt_r <= {1'b0, last[3:1]});
        end
    end
endmodule
`default_nettype wire

// *** adcc_pkg.sv ***
// Shared constants and types of the converter control block.
`default_nettype none
package adcc_pkg;
    // ****************************************
    // Register offsets and fields
    // ****************************************
    localparam logic [3:0] ADDR_CTRL = 4'h0;
    localparam logic [3:0] ADDR_RES_HI = 4'h1;
    localparam logic [3:0] ADDR_RES_LO = 4'h2;
    localparam logic [3:0] ADDR_AMP_CFG = 4'h3;
    localparam logic [3:0] ADDR_CLK_CFG = 4'h4;
    localparam int AMP2_LSB = 4;
    localparam int AMP1_EN_BIT = 3;
    localparam int DIV_LSB = 4;
    localparam int SEL_LSB = 4;
    localparam logic [5:0] AMP_CFG_RST = 6'h02;
    localparam logic [5:0] CLK_CFG_RST = 6'h03;
    localparam logic [2:0] SEL_RST = 3'h0;
    localparam logic [23:0] GAIN_COEF_RST = 24'h010000;
    localparam logic [23:0] OFS_COEF_RST = 24'h000000;
    // ****************************************
    // Mode command codes
    // ****************************************
    localparam logic [3:0] MODE_IDLE = 4'h0;
    localparam logic [3:0] MODE_SINGLE = 4'h2;
    localparam logic [3:0] MODE_CONT = 4'h3;
    localparam logic [3:0] MODE_SINGLE_SWAP = 4'h4;
    localparam logic [3:0] MODE_CONT_SWAP = 4'h5;
    localparam logic [3:0] MODE_CAL_ADC_OFS = 4'h8;
    localparam logic [3:0] MODE_CAL_ADC_GAIN = 4'h9;
    localparam logic [3:0] MODE_CAL_AMP_OFS = 4'ha;
    localparam logic [3:0] MODE_CAL_SYS_OFS = 4'hc;
    localparam logic [3:0] MODE_CAL_SYS_GAIN = 4'hd;
    localparam logic [3:0] MODE_BOOT = 4'hf;
    // ****************************************
    // Analog node codes for the input switches
    // ****************************************
    localparam logic [1:0] NODE_POS = 2'h0;
    localparam logic [1:0] NODE_NEG = 2'h1;
    localparam logic [1:0] NODE_REF = 2'h2;
    localparam logic [1:0] NODE_GND = 2'h3;
    // ****************************************
    // Timing
    // ****************************************
    localparam int CLK_MHZ = 125;
    localparam int BOOT_TIME_NS = 30000;
    localparam logic [11:0] BOOT_CYCLES = 12'((BOOT_TIME_NS * CLK_MHZ + 999) / 1000);
    localparam logic [2:0] MULT_SETTLE = 3'h3;
    localparam logic [2:0] MULT_CONT = 3'h1;
    localparam logic [2:0] MULT_SWAP_SINGLE = 3'h6;
    typedef enum logic [2:0] {
        ST_BOOT = 3'b001,
        ST_IDLE = 3'b010,
        ST_CONV = 3'b100
    } adcc_state_type;
endpackage
`default_nettype wire

// *** tb_adc_conversion_calibration_ctrl.sv ***
// Self-checking testbench of the converter control block.
`default_nettype none
module tb_adc_conversion_calibration_ctrl;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 0, rstn = 0, srst = 0, wr = 0, rd = 0;
    logic [3:0] addr = 4'h0;
    logic [7:0] wdata = 8'h00, rdata, d;
    logic [15:0] fdata;
    logic rdy_n, a1en, swp, mclk, conv;
    logic [1:0] pn, nn, g2;
    logic [2:0] g1;
    logic [23:0] ofs, gain;
    int n_errors = 0, n_tests = 0;
    adcc_filter_model u_flt (.i_sys_clk(clk), .o_data(fdata));
    adcc_ctrl u_dut (.i_sys_clk(clk), .i_resetn(rstn), .i_soft_reset(srst), .i_reg_wr(wr),
        .i_reg_rd(rd), .i_reg_addr(addr), .i_reg_wdata(wdata), .i_filter_data(fdata),
        .o_reg_rdata(rdata), .o_data_ready_n(rdy_n), .o_pos_node(pn), .o_neg_node(nn),
        .o_first_amp_enable(a1en), .o_first_amp_gain(g1), .o_second_amp_gain(g2),
        .o_polarity_swap(swp), .o_modulator_clock(mclk), .o_converting(conv),
        .o_offset_coef(ofs), .o_gain_coef(gain));
    initial begin
        forever #4 clk = ~clk;
    end
    // ****************************************
    // Bus tasks and comparison
    // ****************************************
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr_reg(input logic [3:0] a, input logic [7:0] v);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= v;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1 chk(rdata, exp);
    endtask
    task automatic chk_coef(input logic [23:0] got, input logic [23:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch at %0t: coefficient %h expected %h", $time, got, exp);
        end
    endtask
    // Polling reads are not comparisons, so a changing mode never counts as a mismatch.
    task automatic wait_idle();
        int k;
        logic [7:0] v;
        v = 8'h0f;
        for (k = 0; k < 5000 && v[3:0] !== 4'h0; k++) begin
            @(posedge clk);
            rd <= 1'b1;
            addr <= 4'h0;
            @(posedge clk);
            rd <= 1'b0;
            #1 v = rdata;
        end
        if (k == 5000) begin
            $display("mismatch at %0t: timeout waiting for idle", $time);
            n_errors++;
            conclude();
        end
    endtask
    task automatic wait_rdy();
        int k;
        for (k = 0; k < 4000 && rdy_n !== 1'b0; k++) @(posedge clk);
        if (k == 4000) begin
            $display("mismatch at %0t: timeout waiting for result", $time);
            n_errors++;
            conclude();
        end
        #1;
    endtask
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // ****************************************
    // Test sequence
    // ****************************************
    initial begin
        repeat (16) @(posedge clk);
        rstn <= 1'b1;
        rd_chk(4'h3, 8'h02);
        rd_chk(4'h4, 8'h03);
        rd_chk(4'h0, 8'h8f);
        chk({4'h0, a1en, g1}, 8'h02);
        $display("test reset values done");
        wait_idle();
        rd_chk(4'h0, 8'h80);
        $display("test boot done");
        wr_reg(4'h3, 8'h2f);
        @(posedge clk);
        #1 chk({2'h0, g2, a1en, g1}, 8'h2f);
        rd_chk(4'h3, 8'h2f);
        wr_reg(4'h4, 8'h10);
        rd_chk(4'h4, 8'h10);
        repeat (4) @(posedge clk);
        $display("test configuration done");
        wr_reg(4'h4, 8'h00);
        wr_reg(4'h0, 8'h22);
        repeat (2) @(posedge clk);
        #1 chk({4'h0, pn, nn}, {4'h0, adcc_pkg::NODE_POS, adcc_pkg::NODE_GND});
        wait_rdy();
        rd_chk(4'h0, 8'h20);
        rd_chk(4'h1, 8'h12);
        rd_chk(4'h2, 8'h34);
        #1 chk({7'h0, rdy_n}, 8'h01);
        d = {7'h0, mclk};
        @(posedge clk);
        #1 chk({7'h0, mclk}, d ^ 8'h01);
        $display("test single conversion done");
        wr_reg(4'h0, 8'h08);
        wait_idle();
        chk_coef(ofs, 24'h001234);
        wr_reg(4'h0, 8'h09);
        wait_idle();
        chk_coef(gain, 24'h001234);
        $display("test calibration done");
        wr_reg(4'h0, 8'h04);
        repeat (2) @(posedge clk);
        #1 chk({6'h0, swp, conv}, 8'h03);
        wait_rdy();
        chk({6'h0, swp, rdy_n}, 8'h00);
        rd_chk(4'h1, 8'h12);
        rd_chk(4'h2, 8'h34);
        rd_chk(4'h7, 8'h00);
        $display("test swap conversion done");
        wr_reg(4'h0, 8'h33);
        wait_rdy();
        rd_chk(4'h1, 8'h00);
        rd_chk(4'h2, 8'h00);
        wait_rdy();
        rd_chk(4'h0, 8'h33);
        wr_reg(4'h0, 8'h30);
        rd_chk(4'h0, 8'h30);
        chk({7'h0, conv}, 8'h00);
        $display("test continuous conversion done");
        wr_reg(4'h3, 8'h0b);
        @(posedge clk);
        srst <= 1'b1;
        @(posedge clk);
        srst <= 1'b0;
        rd_chk(4'h3, 8'h02);
        rd_chk(4'h0, 8'h8f);
        chk_coef(gain, 24'h010000);
        chk_coef(ofs, 24'h000000);
        $display("test soft reset done");
        conclude();
    end
endmodule
`default_nettype wire
